// File: core/evbm_pkg.sv
// Constants, types and condition evaluation for the event bit/mask test unit.
// Assumes one clock domain and an AXI4-Lite register port with a 12-bit byte address.
//
// Operation
// - Type 3 line tests one bit given by operand_first against operand_second condition.
// - Bit condition: 0 none, 1 rise, 2 fall, 3 either, 4 level 0, 8 level 1.
// - On bit test hit, target bit kept, set, cleared or toggled by mode 0..3.
// - On bit test hit with a label configured, sequence jumps to that label.
// - Type 4 line ANDs a described register with an immediate 32-bit mask.
// - Mask condition uses bit codes on masked bits; +32 all masked bits must meet it, +0 any.
// - On mask test hit, operand_fourth bit is set to one and label jump taken.
// - Bit descriptor bytes: index low, index high, register kind, bit number.
// - Jump label is 8 bits; 255 means no jump, 0 to 254 select a label.
// - Valid lines evaluated every tick, even when disabled; pending actions run on the first tick after re-enable.
package evbm_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_VALID  = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_MASK   = 12'h00C;
    localparam logic [11:0] OFF_PEND   = 12'h010;
    localparam logic [11:0] OFF_TABLE  = 12'h100;
    localparam int          CTRL_EN_BIT = 0;
    localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
    localparam logic [31:0] RST_VALID  = 32'h0000_0000;
    localparam logic [31:0] RST_MASK   = 32'h0000_0000;

    // ************************************************************
    // Event table layout: eight words per line
    // ************************************************************
    localparam logic [2:0] W_TYPE  = 3'h0;
    localparam logic [2:0] W_OP1   = 3'h1;
    localparam logic [2:0] W_OP2   = 3'h2;
    localparam logic [2:0] W_OP3   = 3'h3;
    localparam logic [2:0] W_OP4   = 3'h4;
    localparam logic [2:0] W_LABEL = 3'h5;
    localparam logic [2:0] W_LAST  = 3'h6;

    // ************************************************************
    // Line types, conditions, modes, labels
    // ************************************************************
    localparam logic [7:0] TYPE_BIT_TEST  = 8'h03;
    localparam logic [7:0] TYPE_MASK_TEST = 8'h04;
    localparam int         COND_RISE_BIT  = 0;
    localparam int         COND_FALL_BIT  = 1;
    localparam int         COND_LVL0_BIT  = 2;
    localparam int         COND_LVL1_BIT  = 3;
    localparam int         COND_ALL_BIT   = 5;
    localparam logic [1:0] MODE_KEEP      = 2'h0;
    localparam logic [1:0] MODE_SET       = 2'h1;
    localparam logic [7:0] LABEL_NONE     = 8'hFF;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // Bit descriptor, byte 0 in the low bits
    typedef struct packed {
        logic [7:0]  bit_num;
        logic [7:0]  kind;
        logic [15:0] index;
    } evbm_desc_s;

    // Bit modification request
    typedef struct packed {
        evbm_desc_s target;
        logic [1:0] op;
    } evbm_bitwr_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_FETCH = 3'b010,
        ST_WAIT  = 3'b011,
        ST_ACT   = 3'b100
    } evbm_state_e;

    // Condition on masked bits; single-bit test passes a one-hot mask
    function automatic logic evbm_cond_met(input logic [7:0]  cond,
                                           input logic [31:0] cur,
                                           input logic [31:0] prev,
                                           input logic [31:0] m,
                                           input logic        have_prev);
        logic [31:0] rise;
        logic [31:0] fall;
        logic        all;
        logic        ev_r;
        logic        ev_f;
        logic        ev_c;
        logic        edge_hit;
        logic        lvl0;
        logic        lvl1;
        rise = ~prev & cur & m;
        fall = prev & ~cur & m;
        all  = cond[COND_ALL_BIT];
        ev_r = all ? (rise == m) : (|rise);
        ev_f = all ? (fall == m) : (|fall);
        ev_c = all ? ((rise | fall) == m) : (|(rise | fall));
        if (!have_prev) begin
            edge_hit = 1'b0;
        end else if (cond[COND_RISE_BIT] && cond[COND_FALL_BIT]) begin
            edge_hit = ev_c;
        end else begin
            edge_hit = (cond[COND_RISE_BIT] && ev_r) || (cond[COND_FALL_BIT] && ev_f);
        end
        lvl0 = all ? ((cur & m) == 32'h0000_0000) : (|(~cur & m));
        lvl1 = all ? ((cur & m) == m) : (|(cur & m));
        return edge_hit || (cond[COND_LVL0_BIT] && lvl0) || (cond[COND_LVL1_BIT] && lvl1);
    endfunction

endpackage

// File: core/evbm_table_mem.sv
// Event table storage: one write port with byte enables, one registered read port.
// Assumes writer and reader share clk; read data appear one edge after the address.
`timescale 1ns/1ns
module evbm_table_mem #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            we,
    input  wire logic [AW-1:0]   waddr,
    input  wire logic [DW-1:0]   wdata,
    input  wire logic [DW/8-1:0] wstrb,
    input  wire logic [AW-1:0]   raddr,
    output logic      [DW-1:0]   rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Byte-lane write
    always_ff @(posedge clk) begin
        for (int b = 0; b < DW/8; b++) begin
            if (we && wstrb[b]) begin
                mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
            end
        end
    end

    // Registered read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // evbm_table_mem

// File: core/evbm_unit.sv
// Event bit/mask test unit: scans the event table once per sample tick.
// Assumes the sequencer answers register reads with reg_rd_valid, and takes
// bit writes and jumps as one-cycle pulses.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module evbm_unit #(
    parameter int LINES = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 sample_tick,
    output logic                      reg_rd_req,
    output evbm_pkg::evbm_desc_s      reg_rd_desc,
    input  wire logic                 reg_rd_valid,
    input  wire logic [31:0]          reg_rd_data,
    output logic                      bit_wr_valid,
    output evbm_pkg::evbm_bitwr_s     bit_wr,
    output logic                      jump_valid,
    output logic [7:0]                jump_label,
    output logic                      irq
);
    import evbm_pkg::*;

    localparam int LW = (LINES > 1) ? $clog2(LINES) : 1;
    localparam int AW = LW + 3;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic              ctrl_en;
    logic [LINES-1:0]  line_valid;
    logic [LINES-1:0]  status;
    logic [LINES-1:0]  irq_mask;
    logic [LINES-1:0]  pending;
    logic [LINES-1:0]  have_prev;
    logic [31:0]       prev_word [0:LINES-1];
    logic              aw_full;
    logic [11:0]       aw_addr;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              ar_full;
    logic [11:0]       ar_addr;
    logic              mem_wait;
    evbm_state_e       st;
    logic [LW-1:0]     cur_line;
    logic [2:0]        wcnt;
    logic              tick_pend;
    logic [7:0]        cfg_type;
    logic [31:0]       cfg_op1;
    logic [31:0]       cfg_op2;
    logic [31:0]       cfg_op3;
    logic [31:0]       cfg_op4;
    logic [7:0]        cfg_label;
    logic [31:0]       sample;
    logic [31:0]       mem_rdata;

    // Address decode shared by read and write paths
    function automatic logic is_table(input logic [11:0] a);
        return (a[11:8] == OFF_TABLE[11:8]) && (32'(a[7:5]) < LINES);
    endfunction

    function automatic logic is_reg(input logic [11:0] a);
        return (a == OFF_CTRL) || (a == OFF_VALID) || (a == OFF_STATUS)
            || (a == OFF_MASK) || (a == OFF_PEND);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // AXI4-Lite handshakes
    // ************************************************************
    wire aw_hs       = s_axi_awvalid && s_axi_awready;
    wire w_hs        = s_axi_wvalid && s_axi_wready;
    wire ar_hs       = s_axi_arvalid && s_axi_arready;
    wire do_write    = aw_full && w_full && !s_axi_bvalid;
    wire wr_tab      = is_table(aw_addr);
    wire wr_ok       = wr_tab || is_reg(aw_addr);
    wire ar_tab      = is_table(ar_addr);
    wire start       = (st == ST_IDLE) && (sample_tick || tick_pend);
    wire rd_go_reg   = ar_full && !s_axi_rvalid && !ar_tab && !mem_wait;
    wire rd_go_tab   = ar_full && !s_axi_rvalid && ar_tab && !mem_wait && (st == ST_IDLE) && !start;
    wire next_aw_full = aw_full ? !do_write : aw_hs;
    wire next_w_full  = w_full ? !do_write : w_hs;
    wire next_bvalid  = s_axi_bvalid ? !s_axi_bready : do_write;
    wire next_ar_full = ar_full ? !(rd_go_reg || mem_wait) : ar_hs;
    wire next_rvalid  = s_axi_rvalid ? !s_axi_rready : (rd_go_reg || mem_wait);

    // Register read mux, narrow fields in the low bits
    wire [31:0] reg_rdata =
        (ar_addr == OFF_CTRL)   ? {31'h0000_0000, ctrl_en} :
        (ar_addr == OFF_VALID)  ? 32'(line_valid) :
        (ar_addr == OFF_STATUS) ? 32'(status) :
        (ar_addr == OFF_MASK)   ? 32'(irq_mask) :
        (ar_addr == OFF_PEND)   ? 32'(pending) : 32'h0000_0000;

    // Write-side register effects
    wire [31:0]      wr_merged  = merge(32'h0000_0000, w_data, w_strb);
    wire             wr_ctrl    = do_write && (aw_addr == OFF_CTRL);
    wire             wr_valid   = do_write && (aw_addr == OFF_VALID);
    wire             wr_mask    = do_write && (aw_addr == OFF_MASK);
    wire [LINES-1:0] status_clr = (do_write && (aw_addr == OFF_STATUS)) ? wr_merged[LINES-1:0] : '0;

    // Write channel state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 12'h000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            if (aw_hs) aw_addr <= s_axi_awaddr;
            if (w_hs) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Write response and ready flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !next_aw_full && !next_bvalid;
            s_axi_wready  <= !next_w_full && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (do_write) s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Read channel, table reads wait for the scanner to go idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ar_full       <= 1'b0;
            ar_addr       <= 12'h000;
            mem_wait      <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            ar_full       <= next_ar_full;
            mem_wait      <= rd_go_tab;
            s_axi_arready <= !next_ar_full && !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_hs) ar_addr <= s_axi_araddr;
            if (rd_go_reg) begin
                s_axi_rdata <= reg_rdata;
                s_axi_rresp <= is_reg(ar_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (mem_wait) begin
                s_axi_rdata <= mem_rdata;
                s_axi_rresp <= RESP_OKAY;
            end
        end
    end

    // ************************************************************
    // Event table memory
    // ************************************************************
    wire [AW-1:0] mem_raddr = (st == ST_IDLE) ? ar_addr[AW+1:2] : {cur_line, wcnt};

    evbm_table_mem #(
        .AW (AW),
        .DW (32)
    ) u_table (
        .clk   (clk),
        .rst   (rst),
        .we    (do_write && wr_tab),
        .waddr (aw_addr[AW+1:2]),
        .wdata (w_data),
        .wstrb (w_strb),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // ************************************************************
    // Line evaluation
    // ************************************************************
    wire             is_bit   = (cfg_type == TYPE_BIT_TEST);
    wire             is_msk   = (cfg_type == TYPE_MASK_TEST);
    wire             line_ok  = line_valid[cur_line] && (is_bit || is_msk);
    wire             last_ln  = (32'(cur_line) == LINES - 1);
    evbm_desc_s      d_test;
    assign d_test = evbm_desc_s'(cfg_op1);
    wire [31:0]      bit_m    = 32'h0000_0001 << d_test.bit_num[4:0];
    wire [31:0]      tmask    = is_bit ? bit_m : cfg_op1;
    wire [7:0]       tcond    = is_bit ? {2'b00, cfg_op2[5:0] & 6'h0F} : cfg_op3[7:0];
    wire [31:0]      cur_word = sample & tmask;
    wire             met      = evbm_cond_met(tcond, cur_word, prev_word[cur_line],
                                              tmask, have_prev[cur_line]);
    wire             fire     = line_ok && (met || pending[cur_line]);
    wire             exec     = fire && ctrl_en;
    wire [1:0]       tmode    = is_bit ? ((cfg_op4 < 32'h4) ? cfg_op4[1:0] : MODE_KEEP)
                                       : MODE_SET;
    wire             act_st   = (st == ST_ACT);
    wire [LINES-1:0] line_hot = LINES'(1) << cur_line;
    wire [LINES-1:0] st_set   = (act_st && exec) ? line_hot : '0;
    wire [LINES-1:0] pd_set   = (act_st && line_ok && met && !ctrl_en) ? line_hot : '0;

    // Control registers; hardware set wins over software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_en    <= RST_CTRL[CTRL_EN_BIT];
            line_valid <= RST_VALID[LINES-1:0];
            irq_mask   <= RST_MASK[LINES-1:0];
            status     <= '0;
            pending    <= '0;
            irq        <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_en <= wr_merged[CTRL_EN_BIT];
            if (wr_valid) line_valid <= wr_merged[LINES-1:0];
            if (wr_mask) irq_mask <= wr_merged[LINES-1:0];
            status  <= (status & ~status_clr) | st_set;
            pending <= (pending & ~st_set) | pd_set;
            irq     <= |(status & irq_mask);
        end
    end

    // Previous sample per line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            have_prev <= '0;
            for (int i = 0; i < LINES; i++) prev_word[i] <= 32'h0000_0000;
        end else if (act_st && line_ok) begin
            prev_word[cur_line] <= cur_word;
            have_prev[cur_line] <= 1'b1;
        end
    end

    // ************************************************************
    // Scanner: every line once per tick
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st           <= ST_IDLE;
            cur_line     <= '0;
            wcnt         <= 3'h0;
            tick_pend    <= 1'b0;
            cfg_type     <= 8'h00;
            cfg_op1      <= 32'h0000_0000;
            cfg_op2      <= 32'h0000_0000;
            cfg_op3      <= 32'h0000_0000;
            cfg_op4      <= 32'h0000_0000;
            cfg_label    <= LABEL_NONE;
            sample       <= 32'h0000_0000;
            reg_rd_req   <= 1'b0;
            reg_rd_desc  <= '0;
            bit_wr_valid <= 1'b0;
            bit_wr       <= '0;
            jump_valid   <= 1'b0;
            jump_label   <= LABEL_NONE;
        end else begin
            reg_rd_req   <= 1'b0;
            bit_wr_valid <= 1'b0;
            jump_valid   <= 1'b0;
            if (sample_tick && !start) tick_pend <= 1'b1;
            unique case (st)
                ST_IDLE: begin
                    if (start) begin
                        tick_pend <= 1'b0;
                        cur_line  <= '0;
                        wcnt      <= W_TYPE;
                        st        <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    wcnt <= wcnt + 3'h1;
                    unique case (wcnt - 3'h1)
                        W_TYPE:  cfg_type  <= mem_rdata[7:0];
                        W_OP1:   cfg_op1   <= mem_rdata;
                        W_OP2:   cfg_op2   <= mem_rdata;
                        W_OP3:   cfg_op3   <= mem_rdata;
                        W_OP4:   cfg_op4   <= mem_rdata;
                        W_LABEL: cfg_label <= mem_rdata[7:0];
                        default: ;
                    endcase
                    if (wcnt == W_LAST) st <= ST_FETCH;
                end
                ST_FETCH: begin
                    if (line_ok) begin
                        reg_rd_req  <= 1'b1;
                        // Register read only: bit number byte sent as zero
                        reg_rd_desc <= is_bit ? evbm_desc_s'({8'h00, cfg_op1[23:0]})
                                              : evbm_desc_s'({8'h00, cfg_op2[23:0]});
                        st          <= ST_WAIT;
                    end else if (last_ln) begin
                        st <= ST_IDLE;
                    end else begin
                        cur_line <= cur_line + LW'(1);
                        wcnt     <= W_TYPE;
                        st       <= ST_LOAD;
                    end
                end
                ST_WAIT: begin
                    if (reg_rd_valid) begin
                        sample <= reg_rd_data;
                        st     <= ST_ACT;
                    end
                end
                ST_ACT: begin
                    if (exec && tmode != MODE_KEEP) begin
                        bit_wr_valid  <= 1'b1;
                        bit_wr.target <= is_bit ? evbm_desc_s'(cfg_op3) : evbm_desc_s'(cfg_op4);
                        bit_wr.op     <= tmode;
                    end
                    if (exec && cfg_label != LABEL_NONE) begin
                        jump_valid <= 1'b1;
                        jump_label <= cfg_label;
                    end
                    if (last_ln) begin
                        st <= ST_IDLE;
                    end else begin
                        cur_line <= cur_line + LW'(1);
                        wcnt     <= W_TYPE;
                        st       <= ST_LOAD;
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end
endmodule // evbm_unit

// File: testbench/evbm_unit_chk.sv
// Checker on the sequencer-side outputs of evbm_unit.
// Assumes it is bound into evbm_unit by the statement at the foot.
`timescale 1ns/1ns
module evbm_unit_chk #(parameter int LINES = 8) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  reg_rd_req,
    input wire evbm_pkg::evbm_desc_s  reg_rd_desc,
    input wire logic                  reg_rd_valid,
    input wire logic                  bit_wr_valid,
    input wire evbm_pkg::evbm_bitwr_s bit_wr,
    input wire logic                  jump_valid,
    input wire logic [7:0]            jump_label
);
    import evbm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_req_pulse: assert property (reg_rd_req |=> !reg_rd_req) else $error("long request");
    chk_desc_top: assert property (reg_rd_req |-> reg_rd_desc.bit_num == 8'h00) else $error("bad desc");
    chk_wr_pulse: assert property (bit_wr_valid |=> !bit_wr_valid) else $error("long write");
    chk_wr_mode: assert property (bit_wr_valid |-> bit_wr.op != 2'h0) else $error("empty write");
    chk_wr_cause: assert property (bit_wr_valid |-> $past(reg_rd_valid, 2)) else $error("early write");
    chk_jump_pulse: assert property (jump_valid |=> !jump_valid) else $error("long jump");
    chk_jump_cause: assert property (jump_valid |-> $past(reg_rd_valid, 2)) else $error("early jump");
    chk_label_real: assert property (jump_valid |-> jump_label != 8'hFF) else $error("null jump");
endmodule // evbm_unit_chk
bind evbm_unit evbm_unit_chk #(.LINES(LINES)) evbm_unit_chk_inst (.clk(clk), .rst(rst), .reg_rd_req(reg_rd_req),
    .reg_rd_desc(reg_rd_desc), .reg_rd_valid(reg_rd_valid), .bit_wr_valid(bit_wr_valid), .bit_wr(bit_wr),
    .jump_valid(jump_valid), .jump_label(jump_label));

// File: testbench/evbm_unit_bench.sv
// Bench for evbm_unit: setup over AXI4-Lite, sequencer reads answered here.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ns
module evbm_unit_bench;
    import evbm_pkg::*;
    logic clk = 0, rst = 1, sample_tick = 0, reg_rd_valid = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, reg_rd_req, bit_wr_valid, jump_valid, irq;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, reg_rd_data = 0, s_axi_rdata, rd_val = 0, rnd = 32'h6604, w[6], d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] jump_label, seen_jl;
    evbm_desc_s reg_rd_desc, seen_rd;
    evbm_bitwr_s bit_wr, seen_wr;
    int mismatches = 0, compares = 0, nwr = 0, cyc = 0;
    // Rows: condition, two samples, hit; last three are mask tests
    localparam int CND[9] = '{1, 2, 3, 4, 8, 1, 33, 33, 1};
    localparam logic [7:0] PV[9] = '{0, 8'h20, 0, 8'h20, 8'h20, 8'h20, 0, 0, 0};
    localparam logic [7:0] CV[9] = '{8'h20, 0, 8'h20, 8'h20, 8'h20, 8'h20, 8'hF0, 8'h10, 8'h10};
    localparam logic [8:0] HIT = 9'h157;
    evbm_unit #(.LINES(2)) evbm_unit_inst (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s); return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
    initial forever #4 clk = ~clk;
    // Sequencer answers one cycle after a request; action monitor; timeout
    always @(posedge clk) begin
        reg_rd_valid <= reg_rd_req;
        reg_rd_data <= rd_val;
        cyc++;
        nwr += int'(bit_wr_valid === 1'b1);
        if (bit_wr_valid === 1'b1) seen_wr = bit_wr;
        if (reg_rd_req === 1'b1) seen_rd = reg_rd_desc;
        if (jump_valid === 1'b1) seen_jl = jump_label;
        if (cyc == 8000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One AXI4-Lite write or read; each channel released when taken
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] v);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (wr ? !s_axi_bvalid : !s_axi_rvalid);
        {s_axi_bready, s_axi_rready} <= 0;
        r = wr ? s_axi_bresp : s_axi_rresp;
        d = s_axi_rdata;
        @(posedge clk);
    endtask
    // One sample tick; random bits above the low byte that holds the tested ones
    task automatic scan(input logic [7:0] v);
        rnd = lfsr(rnd);
        rd_val = {rnd[31:8], v};
        nwr = 0;
        seen_jl = 8'hFF;
        sample_tick <= 1;
        @(posedge clk);
        sample_tick <= 0;
        while (reg_rd_req !== 1'b1) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        bus(0, OFF_VALID, 0);
        chk("valid reset", 34'(RST_VALID), 34'(d));
        bus(0, 12'h020, 0);
        chk("unmapped read", 34'(RESP_SLVERR), 34'(r));
        bus(1, OFF_MASK, 32'h1);
        bus(1, OFF_VALID, 32'h1);
        bus(1, OFF_CTRL, 32'h1);
        chk("write resp", 34'(RESP_OKAY), 34'(r));
        $display("setup done");
        for (int i = 0; i < 9; i++) begin
            if (i < 6) w = '{32'h3, 32'h0501_0007, CND[i], 32'h0002_0003, i % 3 + 1, i};
            else w = '{32'h4, 32'hF0, 32'h0001_0007, CND[i], 32'h0002_0003, i};
            for (int k = 0; k < 6; k++) bus(1, OFF_TABLE + 12'(4 * k), w[k]);
            scan(PV[i]);
            bus(1, OFF_STATUS, 32'h1);
            scan(CV[i]);
            chk("action count", 34'(HIT[i]), 34'(nwr));
            chk("irq level", 34'(HIT[i]), 34'(irq));
            chk("read desc", 34'h10007, 34'(seen_rd));
            if (HIT[i]) begin
                chk("bit write", {32'h0002_0003, i < 6 ? 2'(i % 3 + 1) : MODE_SET}, seen_wr);
                chk("jump label", 34'(i), 34'(seen_jl));
            end
            $display("row %0d done", i);
        end
        // Disabled: hit only recorded as pending, runs after re-enable
        bus(1, OFF_CTRL, 32'h0);
        scan(8'h00);
        scan(8'h10);
        chk("disabled actions", 34'h0, 34'(nwr));
        bus(0, OFF_PEND, 0);
        chk("pending", 34'h1, 34'(d));
        bus(1, OFF_CTRL, 32'h1);
        scan(8'h10);
        chk("re-enable actions", 34'h1, 34'(nwr));
        bus(0, OFF_PEND, 0);
        chk("pending cleared", 34'h0, 34'(d));
        $display("pending test done");
        test_done();
    end
endmodule // evbm_unit_bench
